/* rtl/ubs_pkg.sv */
// Shared constants and types for the bridge status and wake block
package ubs_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ = 100;
	localparam int FILT_NS = 255;
	// Least width that passes the filter, rounded up
	localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_RESET_OUT_SLOW_CYC = 31;
	localparam int HOST_RESET_OUT_SLOW_KHZ = 3000;
	// Least reset pulse, rounded up
	localparam int HOST_RESET_OUT_CYC = (HOST_RESET_OUT_SLOW_CYC * CLK_MHZ * 1000 + HOST_RESET_OUT_SLOW_KHZ - 1) / HOST_RESET_OUT_SLOW_KHZ;

	// ==========================================================
	// Status byte layout
	localparam int BIT_POWER = 7;
	localparam int BIT_BUS_INIT = 6;
	localparam int BIT_TRAFFIC = 5;
	localparam int BIT_RESUME = 4;
	localparam int BIT_EP12 = 3;
	localparam int BIT_EP0 = 2;
	localparam int BIT_HOSTW = 1;
	localparam int BIT_ROUSE = 0;
	localparam logic [7:0] STATE_RST = 8'h81;

	// ==========================================================
	// Filtered input indices
	localparam int IN_FS = 0;
	localparam int IN_SDI = 1;
	localparam int IN_WAKE = 2;
	localparam int N_IN = 3;

	// Events from the packet engine, same clock
	typedef struct packed {
		logic bus_reset;
		logic bus_active;
		logic resume;
		logic ep12_done;
		logic ep0_done;
		logic out_done;
	} ubs_usb_ev_type;

	// Phase of the serial link
	typedef enum logic [1:0] {
		LK_IDLE,
		LK_WRITE,
		LK_READ
	} ubs_link_type;
endpackage

/* rtl/ubs_status_wake.sv */
// Status byte, wake input, input filtering and reset output of the bridge
//
// Contract
// RULE1: Status byte loaded first on read pulse
// RULE2: Bit7 resets set, clears on read/bus reset
// RULE3: Bit6 held during bus reset, read clears
// RULE4: Bit6 clearing enables endpoint zero both ways
// RULE5: Bit5 set on bus activity, read clears
// RULE6: Activity or resume clears clock stop bits
// RULE7: Bit4 follows decoded resume condition
// RULE8: Bit3 set ep1/2 done, write end clears
// RULE9: Bit2 set ep0 done, write end clears
// RULE10: Bit1 set on out done, read end clears
// RULE11: Bit0 inverted wake level, reset one
// RULE12: Inputs synchronised and filtered below 255 ns
// RULE13: Reset output low at least 31 slow cycles
// RULE14: Status byte readable only, never written
// RULE15: Wake input wakes a suspended device
// RULE16: Micro suspends after idle via bit5
// RULE17: Read clears interrupt; events during read held
// RULE18: Serial out is interrupt while select high
// RULE19: Read bits cleared at capture moment
`timescale 1ns/1ps
module ubs_status_wake (
	input wire logic clk,
	input wire logic rstn,
	input wire logic sck,
	input wire logic frame_select,
	input wire logic serial_in_line,
	input wire logic rouse_pin,
	input wire ubs_pkg::ubs_usb_ev_type usb_ev,
	input wire logic suspended,
	input wire logic clocks_stopped,
	input wire logic ep0_disable,
	output logic serial_out_line,
	output logic host_reset_out,
	output logic host_reset_oe,
	output logic ep0_rx_enable,
	output logic ep0_tx_enable,
	output logic clock_stop_clear,
	output logic wake_request,
	output logic [7:0] bridge_state_byte
);
	import ubs_pkg::*;

	localparam int CW = $clog2(FILT_CYC + 1);
	localparam int RW = $clog2(HOST_RESET_OUT_CYC + 1);

	// ==========================================================
	// Input synchroniser and spike filter
	logic [N_IN-1:0] raw, s1, s2;
	logic [N_IN-1:0] filt, filt_d;

	assign raw = {rouse_pin, serial_in_line, frame_select};

	// Two flops ahead of the filter; s1 feeds only s2
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1 <= '0;
			s2 <= '0;
			filt_d <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			filt_d <= filt;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++) begin : g_filt
			logic [CW-1:0] cnt;
			logic [CW-1:0] next_cnt;
			logic f;
			logic next_f;
			// Level must hold for the full window before it is taken
			always_comb begin
				next_cnt = cnt;
				next_f = f;
				if (s2[gi] == f) begin
					next_cnt = '0;
				end else if (cnt == CW'(FILT_CYC - 1)) begin
					next_cnt = '0; // [RULE12]
					next_f = s2[gi];
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					cnt <= '0;
					f <= 1'b0;
				end else begin
					cnt <= next_cnt;
					f <= next_f;
				end
			end
			assign filt[gi] = f;
		end
	endgenerate

	logic fs_lvl;
	logic fs_rise;
	logic fs_fall;
	logic sdi_fall;
	logic wake_rise;
	assign fs_lvl = filt[IN_FS];
	assign fs_rise = filt[IN_FS] & ~filt_d[IN_FS];
	assign fs_fall = ~filt[IN_FS] & filt_d[IN_FS];
	assign sdi_fall = ~filt[IN_SDI] & filt_d[IN_SDI];
	assign wake_rise = filt[IN_WAKE] & ~filt_d[IN_WAKE];

	// ==========================================================
	// Link clock domain: one toggle per falling clock edge
	logic fall_tgl;
	logic next_fall_tgl;
	always_comb begin
		next_fall_tgl = ~fall_tgl;
	end
	// The link clock stops between frames; only whole edges are counted
	always_ff @(negedge sck or negedge rstn) begin
		if (!rstn) begin
			fall_tgl <= 1'b0;
		end else begin
			fall_tgl <= next_fall_tgl;
		end
	end

	// Toggle crossing into the core clock
	logic t1;
	logic t2;
	logic t3;
	logic fall_ev;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			t1 <= 1'b0;
			t2 <= 1'b0;
			t3 <= 1'b0;
		end else begin
			t1 <= fall_tgl;
			t2 <= t1;
			t3 <= t2;
		end
	end
	assign fall_ev = t2 ^ t3;

	// ==========================================================
	// Link phase, status byte, shifter and interrupt latch
	ubs_link_type state, next_state;
	logic [7:0] st, next_st, sh, next_sh;
	logic armed, next_armed, irq, next_irq, held, next_held;
	logic br_d, res_d, capture, irq_ev;
	logic next_rx, next_tx, next_sdo, next_wake_req;

	assign capture = (state == LK_IDLE) && sdi_fall && !fs_lvl;
	assign irq_ev = usb_ev.ep12_done | usb_ev.ep0_done | usb_ev.out_done
		| (usb_ev.resume & ~res_d) | (usb_ev.bus_reset & ~br_d)
		| (wake_rise & clocks_stopped);

	// Software has no write path to the status byte [RULE14]
	always_comb begin
		next_state = state;
		next_st = st;
		next_sh = sh;
		next_armed = armed;
		next_irq = irq;
		next_held = held;
		case (state)
			LK_IDLE: begin
				if (fs_rise) begin
					next_state = LK_WRITE;
				end else if (capture) begin
					next_state = LK_READ;
				end
			end
			LK_WRITE: begin
				if (fs_fall) begin
					next_state = LK_IDLE;
				end
			end
			LK_READ: begin
				if (fs_rise) begin
					next_state = LK_IDLE;
				end
			end
			default: begin
				next_state = LK_IDLE;
			end
		endcase
		// Serial read: first edge keeps bit 0, later edges shift
		if (capture) begin
			next_sh = st; // [RULE1]
			next_armed = 1'b0;
		end else if (state == LK_READ && fall_ev) begin
			if (armed) begin
				next_sh = {1'b0, sh[7:1]};
			end
			next_armed = 1'b1;
		end
		// Read-cleared bits drop at capture; hardware sets win
		if (capture) begin
			next_st[BIT_POWER] = 1'b0; // [RULE19] [RULE2]
			next_st[BIT_BUS_INIT] = 1'b0; // [RULE3]
			next_st[BIT_TRAFFIC] = 1'b0; // [RULE5]
		end
		if (usb_ev.bus_reset && !br_d) begin
			next_st[BIT_POWER] = 1'b0; // [RULE2]
		end
		if (usb_ev.bus_reset) begin
			next_st[BIT_BUS_INIT] = 1'b1; // [RULE3]
		end
		if (usb_ev.bus_active) begin
			next_st[BIT_TRAFFIC] = 1'b1; // [RULE5]
		end
		next_st[BIT_RESUME] = usb_ev.resume; // [RULE7]
		if (state == LK_WRITE && fs_fall) begin
			next_st[BIT_EP12] = 1'b0; // [RULE8]
			next_st[BIT_EP0] = 1'b0; // [RULE9]
		end
		if (usb_ev.ep12_done) begin
			next_st[BIT_EP12] = 1'b1; // [RULE8]
		end
		if (usb_ev.ep0_done) begin
			next_st[BIT_EP0] = 1'b1; // [RULE9]
		end
		if (state == LK_READ && fs_rise) begin
			next_st[BIT_HOSTW] = 1'b0; // [RULE10]
		end
		if (usb_ev.out_done) begin
			next_st[BIT_HOSTW] = 1'b1; // [RULE10]
		end
		next_st[BIT_ROUSE] = ~filt[IN_WAKE]; // [RULE11]
		// Events during a read wait until the read ends
		if (capture) begin
			next_irq = 1'b0; // [RULE17]
		end
		if (state == LK_READ && fs_rise) begin
			next_irq = irq | held | irq_ev; // [RULE17]
			next_held = 1'b0;
		end else if (irq_ev) begin
			if (capture || state == LK_READ) begin
				next_held = 1'b1; // [RULE17]
			end else begin
				next_irq = 1'b1;
			end
		end
	end

	// Side outputs derived from the next status
	always_comb begin
		next_rx = ep0_rx_enable;
		next_tx = ep0_tx_enable;
		if (ep0_disable) begin
			next_rx = 1'b0;
			next_tx = 1'b0;
		end
		// Enable wins over a disable in the same cycle
		if (st[BIT_BUS_INIT] && !next_st[BIT_BUS_INIT]) begin
			next_rx = 1'b1; // [RULE4]
			next_tx = 1'b1;
		end
		// Select high turns the data line into a low-active request
		next_sdo = fs_lvl ? ~next_irq : next_sh[0]; // [RULE18]
		next_wake_req = suspended & wake_rise; // [RULE15]
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= LK_IDLE;
			st <= STATE_RST;
			sh <= '0;
			armed <= 1'b0;
			irq <= 1'b0;
			held <= 1'b0;
			br_d <= 1'b0;
			res_d <= 1'b0;
			ep0_rx_enable <= 1'b0;
			ep0_tx_enable <= 1'b0;
			serial_out_line <= 1'b1;
			clock_stop_clear <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			state <= next_state;
			st <= next_st;
			sh <= next_sh;
			armed <= next_armed;
			irq <= next_irq;
			held <= next_held;
			br_d <= usb_ev.bus_reset;
			res_d <= usb_ev.resume;
			ep0_rx_enable <= next_rx;
			ep0_tx_enable <= next_tx;
			serial_out_line <= next_sdo;
			clock_stop_clear <= next_st[BIT_TRAFFIC] | next_st[BIT_RESUME]; // [RULE6]
			wake_request <= next_wake_req;
		end
	end
	assign bridge_state_byte = st;

	// ==========================================================
	// Open-drain reset output to the microcontroller
	logic [RW-1:0] rc;
	logic [RW-1:0] next_rc;
	logic next_oe;
	always_comb begin
		next_rc = rc;
		next_oe = 1'b0;
		if (rc != RW'(HOST_RESET_OUT_CYC)) begin
			next_rc = rc + 1'b1;
		end
		next_oe = (next_rc != RW'(HOST_RESET_OUT_CYC)); // [RULE13]
	end
	// Pin only ever pulls low; the pull-up sets the idle level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rc <= '0;
			host_reset_oe <= 1'b1;
			host_reset_out <= 1'b0;
		end else begin
			rc <= next_rc;
			host_reset_oe <= next_oe;
			host_reset_out <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_load; capture |=> sh == $past(st); endproperty
	a_load: assert property (p_load) else $error("status not loaded"); // [RULE1]
	property p_clr_read; capture && !usb_ev.bus_reset |=> !st[BIT_POWER] && !st[BIT_BUS_INIT]; endproperty
	a_clr_read: assert property (p_clr_read) else $error("read bits kept"); // [RULE19]
	property p_busy; usb_ev.bus_reset || usb_ev.bus_active |=> st[BIT_BUS_INIT] || st[BIT_TRAFFIC]; endproperty
	a_busy: assert property (p_busy) else $error("bus bits not set"); // [RULE3]
	property p_resume; st[BIT_RESUME] == $past(usb_ev.resume); endproperty
	a_resume: assert property (p_resume) else $error("resume bit wrong"); // [RULE7]
	property p_ep0_en; $fell(st[BIT_BUS_INIT]) |-> ep0_rx_enable && ep0_tx_enable; endproperty
	a_ep0_en: assert property (p_ep0_en) else $error("ep0 not enabled"); // [RULE4]
	property p_wr_end; state == LK_WRITE && fs_fall && !usb_ev.ep12_done && !usb_ev.ep0_done
		|=> !st[BIT_EP12] && !st[BIT_EP0]; endproperty
	a_wr_end: assert property (p_wr_end) else $error("in done kept"); // [RULE8]
	property p_rd_end; state == LK_READ && fs_rise && !usb_ev.out_done |=> !st[BIT_HOSTW]; endproperty
	a_rd_end: assert property (p_rd_end) else $error("out done kept"); // [RULE10]
	property p_rouse; st[BIT_ROUSE] == !$past(filt[IN_WAKE]); endproperty
	a_rouse: assert property (p_rouse) else $error("wake bit wrong"); // [RULE11]
	property p_filt; $changed(filt[IN_SDI]) |-> $past(s2[IN_SDI], FILT_CYC) == filt[IN_SDI]; endproperty
	a_filt: assert property (p_filt) else $error("spike passed"); // [RULE12]
	property p_rst_len; $fell(host_reset_oe) |-> rc == RW'(HOST_RESET_OUT_CYC); endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse short"); // [RULE13]
	property p_irq_pin; $past(fs_lvl) |-> serial_out_line == !irq; endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("irq pin wrong"); // [RULE18]
	// An event during a read, before the cycle it ends, waits in held with irq still low
	property p_irq_hold; state == LK_READ && !fs_rise && irq_ev |=> held && !irq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq not held"); // [RULE17]
	property p_halt; clock_stop_clear == (st[BIT_TRAFFIC] || st[BIT_RESUME]); endproperty
	a_halt: assert property (p_halt) else $error("clock stop clear wrong"); // [RULE6]

	c_read: cover property (capture ##[1:400] (state == LK_READ && fs_rise));
	c_write: cover property (state == LK_WRITE ##[1:400] fs_fall);
	c_ep0: cover property ($fell(st[BIT_BUS_INIT]));
	c_held: cover property (held ##[1:400] irq);
endmodule // ubs_status_wake

/* tb/ubs_micro_model.sv */
// Microcontroller model that drives the serial status link
`timescale 1ns/1ps
module ubs_micro_model (
	output logic sck,
	output logic frame_select,
	output logic serial_in_line,
	input wire logic serial_out_line
);
	// ==========================================================
	// Link pins
	// Link clock parks high between frames; only its falls matter
	initial begin
		sck = 1'b1;
		frame_select = 1'b0;
		serial_in_line = 1'b0;
	end

	// ==========================================================
	// Link transfers
	// Bit taken just before the next fall, since the shift lands late
	task automatic clock_bits(output logic [7:0] data);
		for (int i = 0; i < 8; i++) begin
			sck = 1'b0;
			#40 sck = 1'b1;
			#35 data[i] = serial_out_line;
			#5;
		end
	endtask

	// Status read: sync pulse with select low, then select up
	task automatic read_status(output logic [7:0] data);
		frame_select = 1'b0;
		#500 serial_in_line = 1'b1;
		#400 serial_in_line = 1'b0;
		#600 clock_bits(data);
		frame_select = 1'b1;
		#600;
	endtask

	// Write frame whose data the block ignores
	task automatic write_frame();
		logic [7:0] dummy;
		frame_select = 1'b0;
		#600 frame_select = 1'b1;
		#600 clock_bits(dummy);
		frame_select = 1'b0;
		#600;
	endtask
endmodule // ubs_micro_model

/* tb/testbench.sv */
// Self-checking bench for the bridge status and wake block
`timescale 1ns/1ps
module testbench;
	import ubs_pkg::*;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rouse_pin = 1'b0;
	logic suspended = 1'b0;
	logic clocks_stopped = 1'b0;
	ubs_usb_ev_type usb_ev = '0;
	wire sck;
	wire frame_select;
	wire serial_in_line;
	logic serial_out_line;
	logic host_reset_out;
	logic host_reset_oe;
	logic ep0_rx_enable;
	logic ep0_tx_enable;
	logic clock_stop_clear;
	logic wake_request;
	logic [7:0] bridge_state_byte;
	int num_errors = 0;
	int n_tests = 0;
	int n_wake = 0;

	// Core clock, 100 MHz
	always #5 clk = ~clk;

	ubs_status_wake dut_u (
		.clk(clk),
		.rstn(rstn),
		.sck(sck),
		.frame_select(frame_select),
		.serial_in_line(serial_in_line),
		.rouse_pin(rouse_pin),
		.usb_ev(usb_ev),
		.suspended(suspended),
		.clocks_stopped(clocks_stopped),
		.ep0_disable(1'b0),
		.serial_out_line(serial_out_line),
		.host_reset_out(host_reset_out),
		.host_reset_oe(host_reset_oe),
		.ep0_rx_enable(ep0_rx_enable),
		.ep0_tx_enable(ep0_tx_enable),
		.clock_stop_clear(clock_stop_clear),
		.wake_request(wake_request),
		.bridge_state_byte(bridge_state_byte)
	);

	ubs_micro_model mc_u (
		.sck(sck),
		.frame_select(frame_select),
		.serial_in_line(serial_in_line),
		.serial_out_line(serial_out_line)
	);

	// Wake pulses counted so a missing or doubled pulse shows
	always @(posedge clk) begin
		if (wake_request === 1'b1)
			n_wake <= n_wake + 1;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Step past the edge so its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic end_sim();
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		int cnt;
		cnt = 0;
		cyc(1);
		chk("state_rst", 16'h81, bridge_state_byte);
		chk("host_reset_out_data", 16'h0, host_reset_out);
		while (host_reset_oe === 1'b1 && cnt < 3000) begin
			cyc(1);
			cnt++;
		end
		chk("host_reset_out_long", 16'h1, cnt >= HOST_RESET_OUT_CYC - 1);
		chk("host_reset_out_off", 16'h0, host_reset_oe);
	endtask

	// Bus levels then completion pulses; resume dropped before the read
	task automatic t_events();
		@(posedge clk);
		usb_ev.bus_reset <= 1'b1;
		usb_ev.bus_active <= 1'b1;
		usb_ev.resume <= 1'b1;
		cyc(4);
		chk("resume_bit", 16'h1, bridge_state_byte[BIT_RESUME]);
		chk("stop_clr", 16'h1, clock_stop_clear);
		@(posedge clk);
		usb_ev <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		@(posedge clk);
		usb_ev <= '0;
		cyc(3);
		chk("state_ev", 16'h6f, bridge_state_byte);
		chk("ep0_en_pre", 16'h0, {ep0_rx_enable, ep0_tx_enable});
	endtask

	// Read with an endpoint-zero completion landing mid-read
	task automatic t_read();
		logic [7:0] got;
		fork
			mc_u.read_status(got);
			begin
				#1500;
				@(posedge clk);
				usb_ev.ep0_done <= 1'b1;
				@(posedge clk);
				usb_ev.ep0_done <= 1'b0;
			end
		join
		cyc(1);
		chk("read_byte", 16'h6f, got);
		chk("state_rd", 16'h0d, bridge_state_byte);
		chk("ep0_en", 16'h3, {ep0_rx_enable, ep0_tx_enable});
		chk("stop_clr_off", 16'h0, clock_stop_clear);
		chk("irq_held", 16'h0, serial_out_line);
	endtask

	task automatic t_write();
		mc_u.write_frame();
		cyc(1);
		chk("state_wr", 16'h01, bridge_state_byte);
	endtask

	// A short spike must vanish; a long level must wake
	task automatic t_wake();
		chk("idle_bit", 16'h0, bridge_state_byte[BIT_TRAFFIC]);
		@(posedge clk);
		suspended <= 1'b1;
		clocks_stopped <= 1'b1;
		rouse_pin <= 1'b1;
		repeat (20) @(posedge clk);
		rouse_pin <= 1'b0;
		cyc(40);
		chk("spike_bit", 16'h1, bridge_state_byte[BIT_ROUSE]);
		chk("spike_wake", 16'h0, n_wake);
		@(posedge clk);
		rouse_pin <= 1'b1;
		cyc(40);
		chk("wake_bit", 16'h0, bridge_state_byte[BIT_ROUSE]);
		chk("wake_req", 16'h1, n_wake);
		@(posedge clk);
		rouse_pin <= 1'b0;
		suspended <= 1'b0;
		cyc(40);
		chk("wake_gone", 16'h1, bridge_state_byte[BIT_ROUSE]);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_events();
		t_read();
		t_write();
		t_wake();
		end_sim();
	end

	// Whole run needs well under 30 us; a hang ends here
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end
endmodule // testbench
